// [core/ftl_pkg.sv]
// Constants and types shared by the option and trim loader files
package ftl_pkg;
  // Loader geometry
  localparam int          OPT_BYTES  = 43;
  localparam int          CNT_W      = 6;
  localparam int          STORE_DEP  = 64;
  localparam logic [5:0]  CNT_FIRST  = 6'h00;
  localparam logic [5:0]  CNT_LAST   = 6'h2a;
  localparam logic [5:0]  USER_LAST  = 6'h01;
  localparam logic [6:0]  LOAD_READS = 7'h2b;
  // Trim window inside the information page
  localparam int          TRIM_IDX_W = 5;
  localparam logic        TRIM_BASE  = 1'b1;
  // Register indexes, byte address is four times the index
  localparam logic [11:0] IDX_TRIM_ADDR = 12'hff8;
  localparam logic [11:0] IDX_TRIM_DATA = 12'hff9;
  localparam logic [11:0] IDX_FREQ_HIGH = 12'hffa;
  localparam logic [11:0] IDX_FREQ_LOW  = 12'hffb;
  localparam logic [11:0] IDX_LOAD_STAT = 12'hffc;
  // Reset values
  localparam logic [7:0]  FREQ_HIGH_RST = 8'h00;
  localparam logic [7:0]  FREQ_LOW_RST  = 8'h00;
  localparam logic [4:0]  TRIM_ADDR_RST = 5'h00;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  // Bus timing: wait cycles before every answer
  localparam logic [1:0]  BUS_WAIT      = 2'h2;
  localparam logic [1:0]  BUS_CAPTURE   = 2'h1;
  // Status field position
  localparam int          STAT_DONE_BIT = 0;

  // Loader sequence
  typedef enum logic [1:0] {
    FTL_ST_LOAD  = 2'b00,
    FTL_ST_DRAIN = 2'b01,
    FTL_ST_RUN   = 2'b10
  } ftl_state_e;
endpackage : ftl_pkg

// [core/ftl_mem_if.sv]
// Write and read port bundle between the loader and the option store
`timescale 1ns/100ps
interface ftl_mem_if;
  logic       wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl  (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface : ftl_mem_if

// [core/ftl_opt_store.sv]
// Volatile option latches with one write port and a registered read port
`timescale 1ns/100ps
module ftl_opt_store (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            rst_n_in,
  // Access port
  ftl_mem_if.store                             mem,
  // Loaded option bytes, flattened
  output logic [ftl_pkg::OPT_BYTES*8-1:0]      opt_flat_out
);
  logic [7:0] cell_r [ftl_pkg::STORE_DEP];

  // Latches only, nothing ever writes back to the Flash copies
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < ftl_pkg::STORE_DEP; i++) begin
        cell_r[i] <= ftl_pkg::BYTE_RST;
      end
    end else if (mem.wr_en) begin
      cell_r[mem.wr_addr] <= mem.wr_data;  // [RL6]
    end
  end

  // Read data from a register so the bus path stays short
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem.rd_data <= ftl_pkg::BYTE_RST;
    end else begin
      mem.rd_data <= cell_r[mem.rd_addr];
    end
  end

  // Option bytes fan out to the analog and configuration logic
  for (genvar g = 0; g < ftl_pkg::OPT_BYTES; g++) begin : g_flat
    assign opt_flat_out[g*8 +: 8] = cell_r[g];
  end
endmodule : ftl_opt_store

// [core/ftl_trim_loader.sv]
// Reset-time option loader with trim window and Flash timing registers
//
// Functional notes
// (RL1) User option bytes live at program memory bytes zero and one.
// (RL2) Factory trims stay in the information page; software never rewrites them.
// (RL3) Trim index written first; the next data write replaces that working byte.
// (RL4) Trim index written first; data reads return that working byte.
// (RL5) Trim indexes reach only information locations 20h to 3Fh.
// (RL6) Software trim changes live only in volatile latches.
// (RL7) Reset performs 43 Flash reads; counter gives low six address bits.
// (RL8) Six-bit counter addresses the latches that capture Flash read data.
// (RL9) Counter values zero and one read program memory; later ones information page.
// (RL10) High and low frequency bytes form the 16-bit kHz timing value.
// (RL11) Software programs or erases only between 10 kHz and 20 MHz.
// (RL12) Frequency high byte is read/write and resets to zero.
// (RL13) Frequency low byte is read/write and resets to zero.
// (RL14) Processor stays in reset until every loader read has finished.
// (RL15) Trim index holds until software writes a new one.
`timescale 1ns/100ps
module ftl_trim_loader #(
  parameter int FLASH_AW = 16
) (
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          rstn_in,
  // Avalon-MM register slave
  input  wire logic [13:0]                   avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  input  wire logic [31:0]                   avs_writedata_in,
  output logic [31:0]                        avs_readdata_out,
  output logic                               avs_waitrequest_out,
  // Flash read port, data one cycle after the strobe
  output logic                               flash_rd_out,
  output logic [FLASH_AW-1:0]                flash_addr_out,
  output logic                               flash_info_sel_out,
  input  wire logic [7:0]                    flash_rdata_in,
  // Configuration results
  output logic [ftl_pkg::OPT_BYTES*8-1:0]    option_bits_out,
  output logic [15:0]                        flash_timing_freq_value_out,
  output logic                               cpu_rstn_out
);
  // Reset release synchroniser
  logic [1:0]          rst_sync_r;
  logic                rst_n;
  // Loader state
  ftl_pkg::ftl_state_e state_r;
  ftl_pkg::ftl_state_e state_nxt;
  logic [5:0]          cnt_r;
  logic                cap_vld_r;
  logic [5:0]          cap_idx_r;
  // Registers
  logic [4:0]          trim_addr_r;
  logic [7:0]          freq_high_r;
  logic [7:0]          freq_low_r;
  logic [31:0]         rdata_r;
  logic [1:0]          wait_cnt_r;
  // Bus decode
  logic [11:0]         idx;
  logic                req;
  logic                accept;
  logic                wr_acc;
  logic                trim_wr_acc;
  logic [31:0]         rd_mux;

  ftl_mem_if mem ();

  ftl_opt_store u_store (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n),
    .mem          (mem.store),
    .opt_flat_out (option_bits_out)
  );

  // Async assert, synchronous release of the reset
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Loader sequence: read, drain the last byte, run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ftl_pkg::FTL_ST_LOAD: begin
        if (cnt_r == ftl_pkg::CNT_LAST) begin
          state_nxt = ftl_pkg::FTL_ST_DRAIN;
        end
      end
      ftl_pkg::FTL_ST_DRAIN: begin
        state_nxt = ftl_pkg::FTL_ST_RUN;
      end
      default: begin
        state_nxt = ftl_pkg::FTL_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ftl_pkg::FTL_ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Read counter, one Flash access per cycle while loading
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= ftl_pkg::CNT_FIRST;
    end else if (state_r == ftl_pkg::FTL_ST_LOAD && cnt_r != ftl_pkg::CNT_LAST) begin
      cnt_r <= cnt_r + 6'h01;  // [RL7]
    end
  end

  // Flash read strobe raised only in the load state; no program or erase path exists
  assign flash_rd_out       = (state_r == ftl_pkg::FTL_ST_LOAD);  // [RL7] [RL2]
  assign flash_addr_out     = {{(FLASH_AW-6){1'b0}}, cnt_r};  // [RL7]
  // Bytes zero and one are user options in program memory
  assign flash_info_sel_out = (cnt_r > ftl_pkg::USER_LAST);  // [RL9] [RL1]

  // Capture slot follows the strobe by the Flash read latency
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_vld_r <= 1'b0;
      cap_idx_r <= ftl_pkg::CNT_FIRST;
    end else begin
      cap_vld_r <= flash_rd_out;
      cap_idx_r <= cnt_r;  // [RL8]
    end
  end

  // Processor waits for the last captured byte
  assign cpu_rstn_out = (state_r == ftl_pkg::FTL_ST_RUN);  // [RL14]

  // Bus decode; requests stall until the loader has finished
  assign idx         = avs_address_in[13:2];
  assign req         = avs_read_in | avs_write_in;
  assign accept      = req && (wait_cnt_r == ftl_pkg::BUS_WAIT);
  assign wr_acc      = accept && avs_write_in && avs_byteenable_in[0];
  assign trim_wr_acc = wr_acc && (idx == ftl_pkg::IDX_TRIM_DATA);
  assign avs_waitrequest_out = req && !accept;

  // Wait counter: two wait cycles give the store time to follow a new index
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_r <= 2'h0;
    end else if (accept || !req) begin
      wait_cnt_r <= 2'h0;
    end else if (state_r == ftl_pkg::FTL_ST_RUN) begin
      wait_cnt_r <= wait_cnt_r + 2'h1;
    end
  end

  // Store ports: loader writes first, then software owns the trim window
  always_comb begin
    if (cap_vld_r) begin
      mem.wr_en   = 1'b1;
      mem.wr_addr = cap_idx_r;  // [RL8]
      mem.wr_data = flash_rdata_in;  // [RL8]
    end else begin
      mem.wr_en   = trim_wr_acc;  // [RL3]
      mem.wr_addr = {ftl_pkg::TRIM_BASE, trim_addr_r};  // [RL5]
      mem.wr_data = avs_writedata_in[7:0];  // [RL6]
    end
  end
  assign mem.rd_addr = {ftl_pkg::TRIM_BASE, trim_addr_r};  // [RL4] [RL5]

  // Trim index; only five bits exist so nothing outside the window is reachable
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      trim_addr_r <= ftl_pkg::TRIM_ADDR_RST;
    end else if (wr_acc && idx == ftl_pkg::IDX_TRIM_ADDR) begin
      trim_addr_r <= avs_writedata_in[4:0];  // [RL15] [RL5]
    end
  end

  // Flash frequency bytes
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      freq_high_r <= ftl_pkg::FREQ_HIGH_RST;  // [RL12]
      freq_low_r  <= ftl_pkg::FREQ_LOW_RST;  // [RL13]
    end else if (wr_acc && idx == ftl_pkg::IDX_FREQ_HIGH) begin
      freq_high_r <= avs_writedata_in[7:0];  // [RL12]
    end else if (wr_acc && idx == ftl_pkg::IDX_FREQ_LOW) begin
      freq_low_r  <= avs_writedata_in[7:0];  // [RL13]
    end
  end
  // Value in kHz; software keeps the clock within range
  assign flash_timing_freq_value_out = {freq_high_r, freq_low_r};  // [RL10] [RL11]

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (idx == ftl_pkg::IDX_TRIM_ADDR) begin
      rd_mux[4:0] = trim_addr_r;
    end else if (idx == ftl_pkg::IDX_TRIM_DATA) begin
      rd_mux[7:0] = mem.rd_data;  // [RL4]
    end else if (idx == ftl_pkg::IDX_FREQ_HIGH) begin
      rd_mux[7:0] = freq_high_r;  // [RL12]
    end else if (idx == ftl_pkg::IDX_FREQ_LOW) begin
      rd_mux[7:0] = freq_low_r;  // [RL13]
    end else if (idx == ftl_pkg::IDX_LOAD_STAT) begin
      rd_mux[ftl_pkg::STAT_DONE_BIT] = cpu_rstn_out;
    end
  end

  // Read data captured one cycle before the answer
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_in && wait_cnt_r == ftl_pkg::BUS_CAPTURE) begin
      rdata_r <= rd_mux;
    end
  end
  assign avs_readdata_out = rdata_r;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  logic [6:0] rd_count_r;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_count_r <= 7'h00;
    end else if (flash_rd_out) begin
      rd_count_r <= rd_count_r + 7'h01;
    end
  end

  // Sampled reset keeps the release edge out, the capture slot is still cleared there
  sequence s_load_strobe;
    flash_rd_out && rst_n;
  endsequence
  sequence s_latch;
    mem.wr_en && mem.wr_addr == $past(cnt_r) && mem.wr_data == flash_rdata_in;
  endsequence
  sequence s_wait2;
    avs_waitrequest_out [*2];
  endsequence

  AST_LOAD_ADDR: assert property ( // [RL7]
    flash_rd_out |-> flash_addr_out[FLASH_AW-1:6] == '0)
    else $error("high flash address bits not zero during load");
  AST_LOAD_COUNT: assert property ( // [RL7]
    $rose(cpu_rstn_out) |-> rd_count_r == ftl_pkg::LOAD_READS)
    else $error("loader did not perform exactly 43 reads");
  AST_LATCH: assert property ( // [RL8]
    s_load_strobe |=> s_latch)
    else $error("flash byte not latched at counter address");
  AST_SRC_SEL: assert property ( // [RL9]
    flash_rd_out |-> flash_info_sel_out == (flash_addr_out[5:0] > 6'h01))
    else $error("wrong flash area selected");
  AST_CPU_HOLD: assert property ( // [RL14]
    (cap_vld_r || flash_rd_out) |-> !cpu_rstn_out)
    else $error("processor released while loading");
  AST_TRIM_WR: assert property ( // [RL3]
    trim_wr_acc |-> (mem.wr_en && !cap_vld_r && mem.wr_addr == {ftl_pkg::TRIM_BASE, trim_addr_r})
      ##2 (mem.rd_data == $past(avs_writedata_in[7:0], 2)))
    else $error("trim write hit wrong latch");
  AST_TRIM_MAP: assert property ( // [RL5]
    !cap_vld_r && mem.wr_en |-> mem.wr_addr[5] && mem.rd_addr[5])
    else $error("trim access outside window");
  AST_TRIM_HOLD: assert property ( // [RL15]
    !(wr_acc && idx == ftl_pkg::IDX_TRIM_ADDR) |=> $stable(trim_addr_r))
    else $error("trim index changed without a write");
  AST_FREQ_HIGH: assert property ( // [RL12]
    wr_acc && idx == ftl_pkg::IDX_FREQ_HIGH
      |=> flash_timing_freq_value_out[15:8] == $past(avs_writedata_in[7:0]))
    else $error("frequency high byte not written");
  AST_FREQ_LOW: assert property ( // [RL13]
    wr_acc && idx == ftl_pkg::IDX_FREQ_LOW
      |=> flash_timing_freq_value_out[7:0] == $past(avs_writedata_in[7:0]))
    else $error("frequency low byte not written");
  AST_TRIM_RD: assert property ( // [RL4]
    cpu_rstn_out && $rose(req) && avs_read_in && idx == ftl_pkg::IDX_TRIM_DATA
      |-> s_wait2 ##1 (!avs_waitrequest_out && avs_readdata_out[7:0] == mem.rd_data))
    else $error("trim read answer wrong or late");

  // Software is held off the bus until every option byte is latched
  AST_BUS_STALL: assert property ( // [RL14]
    !cpu_rstn_out && req |-> avs_waitrequest_out)
    else $error("request answered while loading");
  AST_NO_ACCEPT: assert property ( // [RL14]
    accept |-> cpu_rstn_out && !cap_vld_r)
    else $error("request taken before loader finished");

  // Release steps: last strobe, one drain cycle, then the processor runs
  sequence s_last_strobe;
    flash_rd_out && flash_addr_out[5:0] == ftl_pkg::CNT_LAST;
  endsequence
  sequence s_drain_release;
    !flash_rd_out && cap_vld_r && !cpu_rstn_out ##1 cpu_rstn_out;
  endsequence
  AST_RELEASE: assert property ( // [RL14]
    s_last_strobe |=> s_drain_release)
    else $error("processor release not one cycle after the drain");

  // Strobe addresses climb by one each cycle, no address skipped or repeated
  AST_ADDR_STEP: assert property ( // [RL7]
    flash_rd_out && flash_addr_out[5:0] != ftl_pkg::CNT_FIRST
      |-> flash_addr_out[5:0] == $past(flash_addr_out[5:0]) + 6'h01)
    else $error("flash address did not step by one");

  // After loading the Flash port stays quiet, so factory copies are never touched
  AST_FLASH_QUIET: assert property ( // [RL2] [RL6]
    cpu_rstn_out |-> !flash_rd_out && !cap_vld_r)
    else $error("flash accessed after loading");

  // Byte lane zero gates every register write
  AST_LANE_GATE: assert property ( // [RL12] [RL13]
    avs_write_in && !avs_byteenable_in[0]
      |=> $stable(freq_high_r) && $stable(freq_low_r) && $stable(trim_addr_r))
    else $error("write without byte lane zero changed a register");

  // Timing value only moves on a frequency byte write
  AST_TIMING_HOLD: assert property ( // [RL10]
    !(wr_acc && (idx == ftl_pkg::IDX_FREQ_HIGH || idx == ftl_pkg::IDX_FREQ_LOW))
      |=> $stable(flash_timing_freq_value_out))
    else $error("timing value changed without a write");

  // Answer data of the plain registers at the accepting edge
  AST_FREQ_RD_HIGH: assert property ( // [RL12]
    avs_read_in && !avs_waitrequest_out && idx == ftl_pkg::IDX_FREQ_HIGH
      |-> avs_readdata_out == {24'h00_0000, freq_high_r})
    else $error("frequency high byte read back wrong");
  AST_FREQ_RD_LOW: assert property ( // [RL13]
    avs_read_in && !avs_waitrequest_out && idx == ftl_pkg::IDX_FREQ_LOW
      |-> avs_readdata_out == {24'h00_0000, freq_low_r})
    else $error("frequency low byte read back wrong");

  // Index read back shows the held trim index
  AST_TRIM_ADDR_RD: assert property ( // [RL15]
    avs_read_in && !avs_waitrequest_out && idx == ftl_pkg::IDX_TRIM_ADDR
      |-> avs_readdata_out == {27'h000_0000, trim_addr_r})
    else $error("trim index read back wrong");
endmodule : ftl_trim_loader

// [tb/ftl_flash_model.sv]
// Behavioural Flash array answering the reset-time option reads
`timescale 1ns/100ps
module ftl_flash_model #(
  parameter int AW = 16
) (
  // Clock
  input  wire logic          clk_in,
  // Read port
  input  wire logic          rd_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          info_sel_in,
  output logic      [7:0]    rdata_out
);
  // One cycle read latency; no write path, so factory bytes can never change
  // User bytes come from program memory, trims from the information page
  always_ff @(posedge clk_in) begin
    if (rd_in) begin
      rdata_out <= info_sel_in ? (8'h30 + {2'h0, addr_in[5:0]}) : (8'hc0 ^ {2'h0, addr_in[5:0]});
    end else begin
      rdata_out <= ~rdata_out; // Idle bus must not look like a held byte
    end
  end
endmodule : ftl_flash_model

// [tb/flash_option_trim_loader_tb.sv]
// Self-checking bench for the option and trim loader
`timescale 1ns/100ps
module flash_option_trim_loader_tb;
  // Bench signals
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic [13:0]  addr = 14'h0000;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [3:0]   be = 4'h0;
  logic [31:0]  wdata = 32'h0;
  logic [31:0]  rdata;
  logic         waitreq;
  logic         f_rd;
  logic [15:0]  f_addr;
  logic         f_info;
  logic [7:0]   f_data;
  logic [343:0] opts;
  logic [15:0]  freq;
  logic         cpu_rstn;
  logic [15:0]  prev;
  logic [31:0]  rv;
  int           bad;
  int           errors = 0;
  int           tests_run = 0;

  // 50 MHz system clock
  initial begin
    forever #10 clk = ~clk;
  end

  ftl_trim_loader dut (
    .ref_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .flash_rd_out(f_rd),
    .flash_addr_out(f_addr), .flash_info_sel_out(f_info), .flash_rdata_in(f_data),
    .option_bits_out(opts), .flash_timing_freq_value_out(freq), .cpu_rstn_out(cpu_rstn)
  );

  ftl_flash_model flash (
    .clk_in(clk), .rd_in(f_rd), .addr_in(f_addr), .info_sel_in(f_info), .rdata_out(f_data)
  );

  // Strobe tracking; address zero also shows while reset is synchronised
  always @(posedge clk) begin
    if (rstn && f_rd === 1'b1) begin
      if (f_addr !== 16'h0000 && f_addr !== prev + 16'h0001) bad++;
      if (f_info !== (f_addr > 16'h0001)) bad++;
      if (cpu_rstn !== 1'b0) bad++;
      prev = f_addr;
    end
  end

  function automatic logic [7:0] exp_byte(input int a);
    exp_byte = (a < 2) ? (8'hc0 ^ a[7:0]) : (8'h30 + a[7:0]);
  endfunction : exp_byte

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // One Avalon transfer; bound covers the stall during loading
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    be <= b;
    wdata <= {24'h0, d};
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (n == 100) begin
      errors++;
      wrap_up();
    end
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic do_reset();
    rstn <= 1'b0;
    prev = 16'h0;
    bad = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
  endtask : do_reset

  // Main sequence
  initial begin
    do_reset();
    // Read issued during loading must stall until the processor is released
    bus(1'b0, 12'hffa, 8'h00, 4'hf);
    check("cpu reset at answer", {31'h0, cpu_rstn}, 32'h1);
    check("freq high reset", rv, 32'h0);
    check("load strobe faults", 32'(bad), 32'h0);
    check("last load address", {16'h0, prev}, 32'h2a);
    for (int i = 0; i < 43; i++) begin
      check("option byte", {24'h0, opts[8*i +: 8]}, {24'h0, exp_byte(i)});
    end
    bus(1'b0, 12'hffb, 8'h00, 4'hf);
    check("freq low reset", rv, 32'h0);
    // 20 MHz clock gives 20000 kHz; last write lacks byte lane 0
    bus(1'b1, 12'hffa, 8'h4e, 4'hf);
    bus(1'b1, 12'hffb, 8'h20, 4'hf);
    bus(1'b1, 12'hffb, 8'hff, 4'he);
    check("timing value", {16'h0, freq}, 32'h4e20);
    bus(1'b0, 12'hffa, 8'h00, 4'hf);
    check("freq high", rv, 32'h4e);
    bus(1'b0, 12'hffb, 8'h00, 4'hf);
    check("freq low", rv, 32'h20);
    // Index bit 5 is dropped, so this selects trim 3
    bus(1'b1, 12'hff8, 8'h23, 4'hf);
    bus(1'b0, 12'hff9, 8'h00, 4'hf);
    check("trim 3 read", rv, 32'h53);
    bus(1'b1, 12'hff9, 8'h5a, 4'hf);
    bus(1'b0, 12'hff9, 8'h00, 4'hf);
    check("trim 3 override", rv, 32'h5a);
    check("working latch", {24'h0, opts[8*35 +: 8]}, 32'h5a);
    bus(1'b1, 12'hff9, 8'ha5, 4'hf);
    bus(1'b0, 12'hff8, 8'h00, 4'hf);
    check("trim index held", rv, 32'h3);
    bus(1'b0, 12'hff9, 8'h00, 4'hf);
    check("second override", rv, 32'ha5);
    // Top of the window, then a location below it stays untouched
    bus(1'b1, 12'hff8, 8'h1f, 4'hf);
    bus(1'b1, 12'hff9, 8'h77, 4'hf);
    bus(1'b0, 12'hff9, 8'h00, 4'hf);
    check("trim 1f", rv, 32'h77);
    check("below window", {24'h0, opts[8*31 +: 8]}, {24'h0, exp_byte(31)});
    bus(1'b1, 12'hff8, 8'h00, 4'hf);
    bus(1'b0, 12'hff9, 8'h00, 4'hf);
    check("trim 0 read", rv, {24'h0, exp_byte(32)});
    // Unmapped place ignores writes and reads zero
    bus(1'b1, 12'h100, 8'h11, 4'hf);
    bus(1'b0, 12'h100, 8'h00, 4'hf);
    check("unmapped", rv, 32'h0);
    bus(1'b0, 12'hffc, 8'h00, 4'hf);
    check("load status", rv & 32'h1, 32'h1);
    // Second reset restores factory trims and clears the timing value
    do_reset();
    bus(1'b0, 12'hff8, 8'h00, 4'hf);
    check("index after reset", rv, 32'h0);
    check("trim restored", {24'h0, opts[8*35 +: 8]}, {24'h0, exp_byte(35)});
    check("timing after reset", {16'h0, freq}, 32'h0);
    check("reload strobe faults", 32'(bad), 32'h0);
    wrap_up();
  end
endmodule : flash_option_trim_loader_tb
